/* hw/nss_consts.svh */
`ifndef NSS_CONSTS_SVH
`define NSS_CONSTS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NSS_NODES       64
`define NSS_CNT_W       16
`define NSS_ADDR_W      12
`define NSS_DATA_W      32
`define NSS_STAT_W      16

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define NSS_IDX_STATUS  10'h0b2
`define NSS_IDX_CTRL    10'h0c0
`define NSS_IDX_THRESH  10'h0c1
`define NSS_IDX_IRQ_ST  10'h0c2
`define NSS_IDX_IRQ_MSK 10'h0c3

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define NSS_B_SLV_ERR   0
`define NSS_B_REG_CMP   1
`define NSS_B_STOP_ERR  2
`define NSS_B_SLV_DUP   3
`define NSS_B_REP_ERR   4
`define NSS_B_REP_DUP   5
`define NSS_B_ALL_PART  6
`define NSS_B_IO_RUN    7
`define NSS_B_OP_OK     8
`define NSS_B_CNT_WARN  9
`define NSS_B_TBL_EN    10
`define NSS_B_WARN_OR   12
`define NSS_B_ALARM_OR  13

// ----------------------------------------
// Control bits and reset values
// ----------------------------------------
`define NSS_C_TBL_EN    0
`define NSS_C_STOP_EN   1
`define NSS_CTRL_RST    2'h0
`define NSS_THRESH_RST  16'hffff
`define NSS_MASK_RST    16'h0000

`endif

/* hw/nss_pkg.sv */
package nss_pkg;

`include "nss_consts.svh"

    // ----------------------------------------
    // Source conditions from the network engine
    // ----------------------------------------
    typedef struct packed {
        logic [`NSS_NODES-1:0] slv_part;
        logic [`NSS_NODES-1:0] slv_err;
        logic [`NSS_NODES-1:0] rep_part;
        logic [`NSS_NODES-1:0] rep_err;
        logic [`NSS_NODES-1:0] reg_tbl;
        logic [`NSS_NODES-1:0] model_ok;
        logic [`NSS_NODES-1:0] slv_warn;
        logic [`NSS_NODES-1:0] slv_alarm;
        logic                  slv_dup;
        logic                  slv_unstable;
        logic                  rep_dup;
        logic                  rep_unstable;
        logic                  io_run;
        logic [`NSS_CNT_W-1:0] err_count;
    } nss_src_t;

    // ----------------------------------------
    // Whole block state
    // ----------------------------------------
    typedef struct packed {
        logic [`NSS_NODES-1:0]  slv_err;
        logic [`NSS_NODES-1:0]  rep_err;
        logic [`NSS_STAT_W-1:0] status;
        logic [1:0]             ctrl;
        logic [`NSS_CNT_W-1:0]  thresh;
        logic [`NSS_STAT_W-1:0] irq_stat;
        logic [`NSS_STAT_W-1:0] irq_mask;
        logic [`NSS_DATA_W-1:0] prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   irq;
    } nss_state_t;

endpackage : nss_pkg

/* hw/nss_top.sv */
// Notes on behaviour
// RULE1: Bit 0 set while any participating slave has a communications error.
// RULE2: Bit 1 set on joined slave address/model mismatch or unregistered slave.
// RULE3: Bit 1 forced low while the registration table function is off.
// RULE4: Bit 2 mirrors slave error only while stop-on-error is enabled.
// RULE5: Bit 3 set on slave duplicate address or unstable slave link.
// RULE6: Bit 4 set while any participating repeater has a communications error.
// RULE7: Bit 5 set on repeater duplicate address or unstable repeater link.
// RULE8: Bit 6 high only when all registered slaves joined and table on.
// RULE9: Bit 7 high while cyclic I/O runs.
// RULE10: Bit 8 is not bit 0 and bit 6 and bit 7.
// RULE11: Bit 9 high while error counter exceeds the threshold.
// RULE12: Bit 10 shows whether the registration table function is on.
// RULE13: Bit 12 is OR of all slave warning flags.
// RULE14: Bit 13 is OR of all slave alarm flags.
// RULE15: Per-node error flag latches while joined, clears on leaving.
// RULE16: Flags recomputed each cycle; summary read harmless; reserved bits zero.
`timescale 1ns/1ps

`include "nss_consts.svh"

module nss_top
(
    input  wire logic                   clock_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [`NSS_ADDR_W-1:0] paddr_in,
    input  wire logic [`NSS_DATA_W-1:0] pwdata_in,
    input  wire logic [3:0]             pstrb_in,
    input  wire nss_pkg::nss_src_t      src_in,
    output logic      [`NSS_DATA_W-1:0] prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    output logic                        irq_out
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_hit
    (
        input logic [`NSS_ADDR_W-1:0] addr,
        input logic [9:0]             idx
    );
        addr_hit = (addr == {idx, 2'b00});
    endfunction : addr_hit

    function automatic logic [`NSS_DATA_W-1:0] wr_merge
    (
        input logic [`NSS_DATA_W-1:0] old_v,
        input logic [`NSS_DATA_W-1:0] new_v,
        input logic [3:0]             strb
    );
        logic [`NSS_DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        wr_merge = res;
    endfunction : wr_merge

    // ----------------------------------------
    // State
    // ----------------------------------------
    nss_pkg::nss_state_t         r;
    nss_pkg::nss_state_t         n;
    logic [`NSS_STAT_W-1:0]      st;
    logic [`NSS_STAT_W-1:0]      irq_set;
    logic [`NSS_STAT_W-1:0]      irq_clr;
    logic [`NSS_DATA_W-1:0]      rd_val;
    logic [`NSS_DATA_W-1:0]      wm;
    logic                        setup;
    logic                        access;
    logic                        mapped;
    logic                        tbl_en;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        n       = r;
        st      = '0;
        irq_clr = '0;
        rd_val  = '0;
        wm      = '0;
        setup   = psel_in & ~penable_in;
        access  = psel_in & penable_in & r.pready;
        mapped  = addr_hit(paddr_in, `NSS_IDX_STATUS) |
                  addr_hit(paddr_in, `NSS_IDX_CTRL) |
                  addr_hit(paddr_in, `NSS_IDX_THRESH) |
                  addr_hit(paddr_in, `NSS_IDX_IRQ_ST) |
                  addr_hit(paddr_in, `NSS_IDX_IRQ_MSK);

        // Register writes, taken at the access edge
        if (access & pwrite_in & ~r.pslverr)
        begin
            if (addr_hit(paddr_in, `NSS_IDX_CTRL))
            begin
                wm     = wr_merge({30'h0, r.ctrl}, pwdata_in, pstrb_in);
                n.ctrl = wm[1:0];
            end
            if (addr_hit(paddr_in, `NSS_IDX_THRESH))
            begin
                wm       = wr_merge({16'h0, r.thresh}, pwdata_in, pstrb_in);
                n.thresh = wm[`NSS_CNT_W-1:0];
            end
            if (addr_hit(paddr_in, `NSS_IDX_IRQ_MSK))
            begin
                wm         = wr_merge({16'h0, r.irq_mask}, pwdata_in, pstrb_in);
                n.irq_mask = wm[`NSS_STAT_W-1:0];
            end
        end
        tbl_en = n.ctrl[`NSS_C_TBL_EN];

        // Per-node error flags
        n.slv_err = src_in.slv_part & (r.slv_err | src_in.slv_err); // [RULE15]
        n.rep_err = src_in.rep_part & (r.rep_err | src_in.rep_err); // [RULE15]

        // Summary word, rebuilt every cycle
        st[`NSS_B_SLV_ERR]  = |n.slv_err; // [RULE1]
        st[`NSS_B_REG_CMP]  = tbl_en &
            (|(src_in.slv_part & (~src_in.reg_tbl | ~src_in.model_ok))); // [RULE2] [RULE3]
        st[`NSS_B_STOP_ERR] = n.ctrl[`NSS_C_STOP_EN] & (|n.slv_err); // [RULE4]
        st[`NSS_B_SLV_DUP]  = src_in.slv_dup | src_in.slv_unstable; // [RULE5]
        st[`NSS_B_REP_ERR]  = |n.rep_err; // [RULE6]
        st[`NSS_B_REP_DUP]  = src_in.rep_dup | src_in.rep_unstable; // [RULE7]
        st[`NSS_B_ALL_PART] = tbl_en &
            ~(|(src_in.reg_tbl & ~src_in.slv_part)); // [RULE8]
        st[`NSS_B_IO_RUN]   = src_in.io_run; // [RULE9]
        st[`NSS_B_OP_OK]    = ~st[`NSS_B_SLV_ERR] & st[`NSS_B_ALL_PART] &
                              st[`NSS_B_IO_RUN]; // [RULE10]
        st[`NSS_B_CNT_WARN] = (src_in.err_count > n.thresh); // [RULE11]
        st[`NSS_B_TBL_EN]   = tbl_en; // [RULE12]
        st[`NSS_B_WARN_OR]  = |src_in.slv_warn; // [RULE13]
        st[`NSS_B_ALARM_OR] = |src_in.slv_alarm; // [RULE14]
        n.status            = st; // [RULE16]

        // Interrupt: rising flags are sticky, cleared by reading them
        irq_set = st & ~r.status;
        if (access & ~pwrite_in & addr_hit(paddr_in, `NSS_IDX_IRQ_ST))
        begin
            irq_clr = r.prdata[`NSS_STAT_W-1:0];
        end
        n.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
        n.irq      = |(n.irq_stat & n.irq_mask);

        // Read mux, sampled in the setup cycle
        if (addr_hit(paddr_in, `NSS_IDX_STATUS))
        begin
            rd_val = {16'h0, r.status}; // [RULE16]
        end
        else if (addr_hit(paddr_in, `NSS_IDX_CTRL))
        begin
            rd_val = {30'h0, r.ctrl};
        end
        else if (addr_hit(paddr_in, `NSS_IDX_THRESH))
        begin
            rd_val = {16'h0, r.thresh};
        end
        else if (addr_hit(paddr_in, `NSS_IDX_IRQ_ST))
        begin
            rd_val = {16'h0, r.irq_stat};
        end
        else if (addr_hit(paddr_in, `NSS_IDX_IRQ_MSK))
        begin
            rd_val = {16'h0, r.irq_mask};
        end

        // APB answer: ready in the first access cycle
        n.pready  = setup;
        n.pslverr = setup & ~mapped;
        if (setup & ~pwrite_in)
        begin
            n.prdata = rd_val;
        end
        else if (access)
        begin
            n.prdata = r.prdata;
        end
        else
        begin
            n.prdata = '0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            r          <= '0;
            r.ctrl     <= `NSS_CTRL_RST;
            r.thresh   <= `NSS_THRESH_RST;
            r.irq_mask <= `NSS_MASK_RST;
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata_out  = r.prdata;
    assign pready_out  = r.pready;
    assign pslverr_out = r.pslverr;
    assign irq_out     = r.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    slv_err_sum_a: assert property ( // [RULE1]
        (|(src_in.slv_part & src_in.slv_err)) |=> r.status[`NSS_B_SLV_ERR])
        else $error("slave error bit missed");

    reg_cmp_gate_a: assert property ( // [RULE3]
        !r.ctrl[`NSS_C_TBL_EN] |-> !r.status[`NSS_B_REG_CMP])
        else $error("compare error while table off");

    stop_err_a: assert property ( // [RULE4]
        r.status[`NSS_B_STOP_ERR] ==
        (r.status[`NSS_B_SLV_ERR] & r.ctrl[`NSS_C_STOP_EN]))
        else $error("stop flag not gated");

    rep_err_sum_a: assert property ( // [RULE6]
        r.status[`NSS_B_REP_ERR] == (|r.rep_err))
        else $error("repeater error summary wrong");

    all_part_gate_a: assert property ( // [RULE8]
        !r.ctrl[`NSS_C_TBL_EN] |-> !r.status[`NSS_B_ALL_PART])
        else $error("all joined while table off");

    op_ok_and_a: assert property ( // [RULE10]
        r.status[`NSS_B_OP_OK] == (!r.status[`NSS_B_SLV_ERR] &
        r.status[`NSS_B_ALL_PART] & r.status[`NSS_B_IO_RUN]))
        else $error("operation flag wrong");

    cnt_warn_a: assert property ( // [RULE11]
        r.status[`NSS_B_CNT_WARN] == ($past(src_in.err_count) > r.thresh))
        else $error("counter warning wrong");

    tbl_en_a: assert property ( // [RULE12]
        r.status[`NSS_B_TBL_EN] == r.ctrl[`NSS_C_TBL_EN])
        else $error("table state mismatch");

    node_flag_a: assert property ( // [RULE15]
        (!src_in.slv_part[0]) |=> !r.slv_err[0])
        else $error("node flag kept after leaving");

    reserved_zero_a: assert property ( // [RULE16]
        r.status[11] == 1'b0 && r.status[15:14] == 2'h0)
        else $error("reserved bit set");

    apb_ready_a: assert property (
        (psel_in && !penable_in) |=> pready_out ##1 !pready_out)
        else $error("ready not one cycle");

    irq_level_a: assert property (
        irq_out == (|(r.irq_stat & r.irq_mask)))
        else $error("interrupt level wrong");

    reg_cmp_set_a: assert property ( // [RULE2]
        (|(src_in.slv_part & ~src_in.reg_tbl)) |=>
        (r.status[`NSS_B_REG_CMP] || !r.ctrl[`NSS_C_TBL_EN]))
        else $error("compare error bit missed");

    slv_dup_a: assert property ( // [RULE5]
        (src_in.slv_dup || src_in.slv_unstable) |=> r.status[`NSS_B_SLV_DUP])
        else $error("slave duplicate bit missed");

    rep_dup_a: assert property ( // [RULE7]
        (src_in.rep_dup || src_in.rep_unstable) |=> r.status[`NSS_B_REP_DUP])
        else $error("repeater duplicate bit missed");

    io_run_a: assert property ( // [RULE9]
        r.status[`NSS_B_IO_RUN] == $past(src_in.io_run))
        else $error("running bit wrong");

    warn_or_a: assert property ( // [RULE13]
        r.status[`NSS_B_WARN_OR] == (|$past(src_in.slv_warn)))
        else $error("warning summary wrong");

    alarm_or_a: assert property ( // [RULE14]
        r.status[`NSS_B_ALARM_OR] == (|$past(src_in.slv_alarm)))
        else $error("alarm summary wrong");

    irq_sticky_a: assert property (
        $rose(r.status[`NSS_B_IO_RUN]) |-> r.irq_stat[`NSS_B_IO_RUN])
        else $error("interrupt event lost");

    op_ok_c: cover property (r.status[`NSS_B_OP_OK]);
    irq_c: cover property ($rose(irq_out));
    bad_addr_c: cover property (pready_out && pslverr_out);
    stat_read_c: cover property (
        psel_in && !pwrite_in && addr_hit(paddr_in, `NSS_IDX_STATUS) ##1 pready_out);

endmodule : nss_top

/* testbench/nss_src_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Network engine source conditions
// ----------------------------------------
module nss_src_model
(
    input  wire logic          clock_in,
    output nss_pkg::nss_src_t  src_out
);
    initial src_out = '0;

    task automatic apply(input nss_pkg::nss_src_t v);
        @(posedge clock_in);
        src_out <= v;
    endtask : apply
endmodule : nss_src_model

/* testbench/nss_bench.sv */
`timescale 1ns/1ps

`include "nss_consts.svh"

module nss_bench;
    localparam logic [11:0] A_STAT = {`NSS_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_CTRL = {`NSS_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_TH   = {`NSS_IDX_THRESH, 2'b00};
    localparam logic [11:0] A_IST  = {`NSS_IDX_IRQ_ST, 2'b00};
    localparam logic [11:0] A_MSK  = {`NSS_IDX_IRQ_MSK, 2'b00};

    logic              clk;
    logic              rst_n;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    nss_pkg::nss_src_t src_v;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [15:0]       th = 16'hffff;
    int                err_count = 0;
    int                comparisons = 0;

    nss_top dut
    (
        .clock_in    (clk),
        .rst_n_in    (rst_n),
        .psel_in     (psel),
        .penable_in  (penable),
        .pwrite_in   (pwrite),
        .paddr_in    (paddr),
        .pwdata_in   (pwdata),
        .pstrb_in    (pstrb),
        .src_in      (src_v),
        .prdata_out  (prdata),
        .pready_out  (pready),
        .pslverr_out (pslverr),
        .irq_out     (irq)
    );

    nss_src_model src
    (
        .clock_in (clk),
        .src_out  (src_v)
    );

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // APB master
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] st, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        check(r, exp);
        check({31'h0, e}, 32'h0);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, 4'hf, r, e);
    endtask : wr

    function automatic logic [31:0] exp_stat(nss_pkg::nss_src_t s, logic [1:0] c);
        logic [15:0] v;
        v = '0;
        v[0] = |(s.slv_part & s.slv_err);
        v[1] = c[0] & |(s.slv_part & ~(s.reg_tbl & s.model_ok));
        v[2] = c[1] & v[0];
        v[3] = s.slv_dup | s.slv_unstable;
        v[4] = |(s.rep_part & s.rep_err);
        v[5] = s.rep_dup | s.rep_unstable;
        v[6] = c[0] & ((s.reg_tbl & ~s.slv_part) == '0);
        v[7] = s.io_run;
        v[8] = ~v[0] & v[6] & v[7];
        v[9] = s.err_count > th;
        v[10] = c[0];
        v[12] = |s.slv_warn;
        v[13] = |s.slv_alarm;
        return {16'h0, v};
    endfunction : exp_stat

    task automatic run(input nss_pkg::nss_src_t s, input logic [1:0] c);
        wr(A_CTRL, {30'h0, c});
        src.apply('0);
        repeat (3) @(posedge clk);
        src.apply(s);
        repeat (3) @(posedge clk);
        rd(A_STAT, exp_stat(s, c));
    endtask : run

    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        #20000;
        err_count++;
        end_sim();
    end

    initial
    begin
        nss_pkg::nss_src_t s;
        logic [31:0]       r;
        logic              e;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(A_CTRL, 32'h0);
        rd(A_TH, 32'h0000ffff);
        rd(A_MSK, 32'h0);
        wr(A_STAT, 32'hffffffff);
        rd(A_STAT, 32'h0);
        apb(1'b0, 12'h010, 32'h0, 4'h0, r, e);
        check({31'h0, e}, 32'h1);
        apb(1'b1, A_TH, 32'h00001234, 4'h1, r, e);
        rd(A_TH, 32'h0000ff34);
        wr(A_TH, 32'h00000010);
        th = 16'h0010;
        s = '0;
        s.slv_part[5] = 1'b1;
        s.slv_err[5] = 1'b1;
        run(s, 2'h2);
        run(s, 2'h0);
        s.slv_part[5] = 1'b0;
        run(s, 2'h2);
        s = '0;
        s.rep_part[63] = 1'b1;
        s.rep_err[63] = 1'b1;
        run(s, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            s = '0;
            {s.slv_dup, s.slv_unstable, s.rep_dup, s.rep_unstable} = 4'h8 >> i;
            run(s, 2'h0);
        end
        s = '0;
        s.reg_tbl[2:1] = 2'h3;
        s.model_ok = '1;
        s.slv_part[1] = 1'b1;
        s.io_run = 1'b1;
        run(s, 2'h1);
        s.slv_part[2] = 1'b1;
        run(s, 2'h1);
        run(s, 2'h0);
        s.slv_part[3] = 1'b1;
        run(s, 2'h1);
        run(s, 2'h0);
        s.slv_part[3] = 1'b0;
        s.model_ok[1] = 1'b0;
        run(s, 2'h1);
        s = '0;
        s.slv_warn[40] = 1'b1;
        run(s, 2'h0);
        s = '0;
        s.slv_alarm[40] = 1'b1;
        run(s, 2'h0);
        s = '0;
        s.err_count = 16'h0010;
        run(s, 2'h0);
        s.err_count = 16'h0011;
        run(s, 2'h0);
        s = '0;
        s.slv_part[7] = 1'b1;
        s.slv_err[7] = 1'b1;
        run(s, 2'h0);
        s.slv_err[7] = 1'b0;
        src.apply(s);
        repeat (3) @(posedge clk);
        rd(A_STAT, 32'h1);
        s.slv_part[7] = 1'b0;
        src.apply(s);
        repeat (3) @(posedge clk);
        rd(A_STAT, 32'h0);
        apb(1'b0, A_IST, 32'h0, 4'h0, r, e);
        s.io_run = 1'b1;
        src.apply(s);
        repeat (5) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(A_IST, 32'h80);
        rd(A_IST, 32'h0);
        wr(A_MSK, 32'h80);
        rd(A_MSK, 32'h80);
        s.io_run = 1'b0;
        src.apply(s);
        repeat (3) @(posedge clk);
        s.io_run = 1'b1;
        src.apply(s);
        repeat (5) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd(A_IST, 32'h80);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule : nss_bench
